// >>> csw_pkg.sv
// How it works
// - Low-power select: clear flag, switch, primary off
// - Hold first phase for eight low-power edges
// - Flag low-power oscillator as system clock
// - Disabled low-power oscillator remaps select writes
// - Switch only when resolved select differs
// - Crystal return counts 1024 edges, keeps running
// - Primary flag set after count, primary clock
// - Hold first phase for eight primary edges
// - Enable cleared in low-power mode clears bit0
// - Low-power oscillator runs until count completes
// - External or resistor-cap primary adds short delay
// - Non-crystal primary skips the start-up count
// - Internal RC off unless watchdog/monitor use, it is the selected source or it is the primary
// - Low-power oscillator stays on while enabled
// - Reset clears select, defaults to primary
// - Reset with crystal holds for 1024 edges
// - Two-speed start-up runs from internal RC
// - Start-up timers parallel, one extra cycle
// - Reset with non-crystal primary holds delay
// - Fast internal stable flag about 4 ms later
// - Internal select output follows frequency select
// - Select encodes primary, low-power, internal RC
package csw_pkg;
   // Register byte offsets
   localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
   localparam logic [3:0] T1_CTRL_OFS = 4'h4;
   // Oscillator control layout
   localparam int IFS_LSB = 4;
   localparam int PRIM_RUN_BIT = 3;
   localparam int FAST_STABLE_BIT = 2;
   // Timer one control layout
   localparam int LP_EN_BIT = 3;
   localparam int LP_RUN_BIT = 6;
   // Clock select codes
   localparam logic [1:0] SEL_PRIMARY = 2'h0;
   localparam logic [1:0] SEL_LP_OSC = 2'h1;
   localparam logic [1:0] SEL_INT_RC = 2'h2;
   localparam logic [1:0] SEL_RSVD = 2'h3;
   // Primary oscillator configuration codes
   localparam logic [2:0] CFG_LP_XTAL = 3'h0;
   localparam logic [2:0] CFG_STD_XTAL = 3'h1;
   localparam logic [2:0] CFG_HS_XTAL = 3'h2;
   localparam logic [2:0] CFG_EXT_CLK = 3'h3;
   localparam logic [2:0] CFG_RES_CAP = 3'h4;
   localparam logic [2:0] CFG_INT_RC = 3'h5;
   // Reset values
   localparam logic [2:0] IFS_RESET = 3'h0;
   localparam logic [2:0] IFS_SLOWEST = 3'h0;
   // Timing
   localparam int CLK_NS = 40;
   localparam int OST_EDGES = 1024;
   localparam int HOLD_EDGES = 8;
   localparam int CPU_DLY_MIN_US = 5;
   localparam int CPU_DLY_CYC = (CPU_DLY_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int FAST_STABLE_MS = 4;
   localparam int FAST_STABLE_CYC = (FAST_STABLE_MS * 1000000) / CLK_NS;
   // Sequencer states, one-hot
   typedef enum logic [6:0] {
      ST_RST_WAIT = 7'h01,
      ST_RST_EXTRA = 7'h02,
      ST_RUN = 7'h04,
      ST_OST = 7'h08,
      ST_HOLD = 7'h10,
      ST_DLY = 7'h20,
      ST_UNUSED = 7'h40
   } csw_fsm_t;
   // Oscillator sample pipe: primary, low-power, internal RC
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
   } csw_sync_t;
   // All block state
   typedef struct packed {
      csw_fsm_t fsm;
      csw_sync_t sync;
      logic [1:0] sel;
      logic [1:0] cur_src;
      logic [2:0] ifs;
      logic lp_en;
      logic prim_run;
      logic fast_stable;
      logic prim_pwr;
      logic lp_pwr;
      logic rc_pwr;
      logic hold;
      logic [10:0] edge_cnt;
      logic ost_done;
      logic [6:0] dly_cnt;
      logic dly_done;
      logic [16:0] fast_cnt;
      logic fast_busy;
      logic ack;
      logic [31:0] rdata;
   } csw_state_t;
endpackage : csw_pkg

// >>> csw_switcher.sv
`timescale 1ns/10ps
`default_nettype none
module csw_switcher #(
   parameter int FAST_STABLE_CYC = csw_pkg::FAST_STABLE_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [2:0] primary_osc_config,
   input wire logic two_speed_en,
   input wire logic watchdog_uses_rc,
   input wire logic fail_safe_uses_rc,
   input wire logic cpu_startup_done,
   input wire logic primary_clk_in,
   input wire logic lp_osc_clk_in,
   input wire logic rc_osc_clk_in,
   output logic [1:0] sys_clk_source,
   output logic [2:0] internal_freq_select,
   output logic first_phase_hold,
   output logic watchdog_pause,
   output logic primary_osc_pwr,
   output logic lp_osc_pwr,
   output logic rc_osc_pwr
);
   csw_pkg::csw_state_t st_reg;
   csw_pkg::csw_state_t st_next;
   logic req;
   logic wr_ok;
   logic [2:0] fall;
   logic src_fall;
   logic crystal;
   logic short_dly;
   logic [1:0] wsel;
   // Top bit of the frequency select field, three bits wide
   localparam int IFS_MSB = csw_pkg::IFS_LSB + 2;

   // Crystal primaries need the start-up count
   function automatic logic is_crystal(input logic [2:0] cfg);
      is_crystal = (cfg == csw_pkg::CFG_LP_XTAL) || (cfg == csw_pkg::CFG_STD_XTAL) ||
                   (cfg == csw_pkg::CFG_HS_XTAL);
   endfunction : is_crystal

   // Remap a select write; the reserved code falls back to internal RC
   function automatic logic [1:0] resolve_sel(input logic [1:0] v, input logic lp_en);
      if (v == csw_pkg::SEL_RSVD)
         resolve_sel = csw_pkg::SEL_INT_RC;
      else if ((v == csw_pkg::SEL_LP_OSC) && !lp_en)
         resolve_sel = csw_pkg::SEL_PRIMARY;
      else
         resolve_sel = v;
   endfunction : resolve_sel

   // Bus and oscillator edge decoding
   assign req = avs_read || avs_write;
   assign wr_ok = avs_write && st_reg.ack;
   assign fall = st_reg.sync.s3 & ~st_reg.sync.s2;
   assign crystal = is_crystal(primary_osc_config);
   assign short_dly = (primary_osc_config == csw_pkg::CFG_EXT_CLK) ||
                      (primary_osc_config == csw_pkg::CFG_RES_CAP);
   assign wsel = resolve_sel(avs_writedata[1:0], st_reg.lp_en);

   // Falling edge of the oscillator that currently drives the system
   always_comb
   begin
      unique case (st_reg.cur_src)
         csw_pkg::SEL_LP_OSC: src_fall = fall[1];
         csw_pkg::SEL_INT_RC: src_fall = fall[2];
         default: src_fall = fall[0];
      endcase
   end

   // Next state of the whole block
   always_comb
   begin
      st_next = st_reg;
      // Oscillator inputs are asynchronous: two flops, then a third for edges
      st_next.sync.s1 = {rc_osc_clk_in, lp_osc_clk_in, primary_clk_in};
      st_next.sync.s2 = st_reg.sync.s1;
      st_next.sync.s3 = st_reg.sync.s2;

      // One wait cycle per access; read data loaded while waiting
      st_next.ack = req && !st_reg.ack;
      st_next.rdata = 32'h0000_0000;
      if (avs_read && !st_reg.ack)
      begin
         if (avs_address == csw_pkg::OSC_CTRL_OFS)
         begin
            st_next.rdata[IFS_MSB:csw_pkg::IFS_LSB] = st_reg.ifs;
            st_next.rdata[csw_pkg::PRIM_RUN_BIT] = st_reg.prim_run;
            st_next.rdata[csw_pkg::FAST_STABLE_BIT] = st_reg.fast_stable;
            st_next.rdata[1:0] = st_reg.sel;
         end
         else if (avs_address == csw_pkg::T1_CTRL_OFS)
         begin
            st_next.rdata[csw_pkg::LP_EN_BIT] = st_reg.lp_en;
            st_next.rdata[csw_pkg::LP_RUN_BIT] = (st_reg.cur_src == csw_pkg::SEL_LP_OSC);
         end
      end

      // Register writes; status bits are read-only
      if (wr_ok && avs_byteenable[0] && (avs_address == csw_pkg::OSC_CTRL_OFS))
      begin
         st_next.ifs = avs_writedata[IFS_MSB:csw_pkg::IFS_LSB];
         st_next.sel = wsel;
      end
      if (wr_ok && avs_byteenable[0] && (avs_address == csw_pkg::T1_CTRL_OFS))
      begin
         st_next.lp_en = avs_writedata[csw_pkg::LP_EN_BIT];
         // Dropping the enable while low-power is selected falls back to primary
         if (!avs_writedata[csw_pkg::LP_EN_BIT] && (st_reg.sel == csw_pkg::SEL_LP_OSC))
            st_next.sel = csw_pkg::SEL_PRIMARY;
      end

      // Fast internal oscillator settle timer
      if (st_reg.fast_busy)
      begin
         if (st_reg.fast_cnt == 17'(FAST_STABLE_CYC - 1))
         begin
            st_next.fast_busy = 1'b0;
            st_next.fast_stable = 1'b1;
         end
         else
            st_next.fast_cnt = st_reg.fast_cnt + 17'h0_0001;
      end

      unique case (st_reg.fsm)
         // Reset recovery: oscillator count and delay run beside the CPU timer
         csw_pkg::ST_RST_WAIT:
         begin
            st_next.cur_src = (crystal && two_speed_en) ? csw_pkg::SEL_INT_RC : csw_pkg::SEL_PRIMARY;
            st_next.hold = !(crystal && two_speed_en);
            st_next.prim_pwr = 1'b1;
            if (crystal && !st_reg.ost_done && fall[0])
            begin
               st_next.edge_cnt = st_reg.edge_cnt + 11'h001;
               if (st_reg.edge_cnt == 11'(csw_pkg::OST_EDGES - 1))
                  st_next.ost_done = 1'b1;
            end
            if (!crystal && !st_reg.dly_done)
            begin
               st_next.dly_cnt = st_reg.dly_cnt + 7'h01;
               if (st_reg.dly_cnt == 7'(csw_pkg::CPU_DLY_CYC - 1))
                  st_next.dly_done = 1'b1;
            end
            if ((crystal ? st_reg.ost_done : st_reg.dly_done) && cpu_startup_done)
               st_next.fsm = csw_pkg::ST_RST_EXTRA;
         end
         // The extra cycle after both timers are done
         csw_pkg::ST_RST_EXTRA:
         begin
            st_next.cur_src = csw_pkg::SEL_PRIMARY;
            st_next.prim_run = 1'b1;
            st_next.hold = 1'b0;
            st_next.fsm = csw_pkg::ST_RUN;
         end
         // Running: start a transition only if the select really changed
         csw_pkg::ST_RUN:
         begin
            st_next.edge_cnt = 11'h000;
            st_next.dly_cnt = 7'h00;
            if (st_reg.sel != st_reg.cur_src)
            begin
               if (st_reg.sel == csw_pkg::SEL_PRIMARY)
               begin
                  st_next.prim_pwr = 1'b1;
                  if (crystal)
                     st_next.fsm = csw_pkg::ST_OST;
                  else
                  begin
                     st_next.cur_src = csw_pkg::SEL_PRIMARY;
                     st_next.prim_run = 1'b1;
                     st_next.hold = 1'b1;
                     st_next.fsm = csw_pkg::ST_HOLD;
                  end
               end
               else
               begin
                  // Secondary entry: primary stops at once to save power
                  st_next.prim_run = 1'b0;
                  st_next.prim_pwr = 1'b0;
                  st_next.cur_src = st_reg.sel;
                  st_next.hold = 1'b1;
                  st_next.fsm = csw_pkg::ST_HOLD;
                  if ((st_reg.sel == csw_pkg::SEL_INT_RC) && (st_reg.ifs != csw_pkg::IFS_SLOWEST))
                  begin
                     st_next.fast_stable = 1'b0;
                     st_next.fast_busy = 1'b1;
                     st_next.fast_cnt = 17'h0_0000;
                  end
               end
            end
         end
         // Crystal warm-up while execution stays on the secondary clock
         csw_pkg::ST_OST:
         begin
            if (fall[0])
            begin
               st_next.edge_cnt = st_reg.edge_cnt + 11'h001;
               if (st_reg.edge_cnt == 11'(csw_pkg::OST_EDGES - 1))
               begin
                  st_next.edge_cnt = 11'h000;
                  st_next.cur_src = csw_pkg::SEL_PRIMARY;
                  st_next.prim_run = 1'b1;
                  st_next.hold = 1'b1;
                  st_next.fsm = csw_pkg::ST_HOLD;
               end
            end
         end
         // First-phase hold for eight falling edges of the new source
         csw_pkg::ST_HOLD:
         begin
            if (src_fall)
            begin
               st_next.edge_cnt = st_reg.edge_cnt + 11'h001;
               if (st_reg.edge_cnt == 11'(csw_pkg::HOLD_EDGES - 1))
               begin
                  if ((st_reg.cur_src == csw_pkg::SEL_PRIMARY) && short_dly)
                     st_next.fsm = csw_pkg::ST_DLY;
                  else
                  begin
                     st_next.hold = 1'b0;
                     st_next.fsm = csw_pkg::ST_RUN;
                  end
               end
            end
         end
         // CPU settle delay after leaving secondary mode
         csw_pkg::ST_DLY:
         begin
            st_next.dly_cnt = st_reg.dly_cnt + 7'h01;
            if (st_reg.dly_cnt == 7'(csw_pkg::CPU_DLY_CYC - 1))
            begin
               st_next.hold = 1'b0;
               st_next.fsm = csw_pkg::ST_RUN;
            end
         end
         // Unused code: recover by running on the current source
         default:
         begin
            st_next.hold = 1'b0;
            st_next.fsm = csw_pkg::ST_RUN;
         end
      endcase

      // Low-power oscillator stays up while enabled or still clocking
      st_next.lp_pwr = st_next.lp_en || (st_next.cur_src == csw_pkg::SEL_LP_OSC);
      // Internal RC stays up only while something needs it
      st_next.rc_pwr = (st_next.cur_src == csw_pkg::SEL_INT_RC) || watchdog_uses_rc ||
                       fail_safe_uses_rc ||
                       ((st_next.cur_src == csw_pkg::SEL_PRIMARY) &&
                        (primary_osc_config == csw_pkg::CFG_INT_RC));
   end

   // Single state register; reset loads the primary, but a two-speed crystal start-up then runs on internal RC
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.fsm <= csw_pkg::ST_RST_WAIT;
         st_reg.sel <= csw_pkg::SEL_PRIMARY;
         st_reg.cur_src <= csw_pkg::SEL_PRIMARY;
         st_reg.ifs <= csw_pkg::IFS_RESET;
         st_reg.prim_pwr <= 1'b1;
         st_reg.rc_pwr <= 1'b1;
         st_reg.hold <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // Outputs
   assign avs_waitrequest = req && !st_reg.ack;
   assign avs_readdata = st_reg.rdata;
   assign sys_clk_source = st_reg.cur_src;
   assign internal_freq_select = st_reg.ifs;
   assign first_phase_hold = st_reg.hold;
   // Watchdog counter doubles as start-up counter during transitions
   assign watchdog_pause = (st_reg.fsm != csw_pkg::ST_RUN);
   assign primary_osc_pwr = st_reg.prim_pwr;
   assign lp_osc_pwr = st_reg.lp_pwr;
   assign rc_osc_pwr = st_reg.rc_pwr;
endmodule : csw_switcher
`default_nettype wire

// >>> csw_switcher_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module csw_switcher_monitor #(
   parameter int FAST_STABLE_CYC = 50
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] primary_osc_config,
   input wire logic two_speed_en,
   input wire logic watchdog_uses_rc,
   input wire logic fail_safe_uses_rc,
   input wire logic cpu_startup_done,
   input wire logic [1:0] sys_clk_source,
   input wire logic first_phase_hold,
   input wire logic watchdog_pause,
   input wire logic primary_osc_pwr,
   input wire logic lp_osc_pwr,
   input wire logic rc_osc_pwr
);
   logic xtal;
   logic slow_cfg;
   logic [7:0] hold_cnt_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Crystal primaries need the start-up count; external clock and resistor-cap take the fixed delay
   assign xtal = primary_osc_config <= csw_pkg::CFG_HS_XTAL;
   assign slow_cfg = primary_osc_config == csw_pkg::CFG_EXT_CLK || primary_osc_config == csw_pkg::CFG_RES_CAP;
   // Length of the current hold, saturating so a long hold never wraps to a small count
   always_ff @(posedge mclk)
   begin
      if (rst || !first_phase_hold)
         hold_cnt_reg <= 8'h00;
      else if (hold_cnt_reg != 8'hFF)
         hold_cnt_reg <= hold_cnt_reg + 8'h01;
   end
   lp_entry_a:
      assert property ($changed(sys_clk_source) && sys_clk_source == csw_pkg::SEL_LP_OSC
         |-> (!primary_osc_pwr && first_phase_hold) [*8]) else $error("low-power entry without hold or power-down");
   lp_power_a:
      assert property (sys_clk_source == csw_pkg::SEL_LP_OSC |-> lp_osc_pwr) else $error("low-power osc off in use");
   prim_entry_a:
      assert property ($changed(sys_clk_source) && sys_clk_source == csw_pkg::SEL_PRIMARY && !two_speed_en
         |-> (first_phase_hold && primary_osc_pwr) [*8]) else $error("primary entry without hold");
   slow_hold_a:
      assert property ($fell(first_phase_hold) && slow_cfg && sys_clk_source == csw_pkg::SEL_PRIMARY
         |-> hold_cnt_reg >= 8'h7D) else $error("fixed delay too short");
   reset_state_a:
      assert property (disable iff (1'b0) rst |=> sys_clk_source == csw_pkg::SEL_PRIMARY && first_phase_hold
         && primary_osc_pwr && !lp_osc_pwr) else $error("reset state wrong");
   two_speed_a:
      assert property ($fell(rst) && xtal && two_speed_en |-> ##[0:3] sys_clk_source == csw_pkg::SEL_INT_RC)
         else $error("two-speed start not on internal RC");
   xtal_reset_a:
      assert property ($fell(rst) && xtal && !two_speed_en |-> (first_phase_hold && watchdog_pause) [*8])
         else $error("crystal reset released early");
   rc_off_a:
      assert property (!watchdog_pause && !$past(watchdog_pause) && !$past(watchdog_uses_rc) && !$past(fail_safe_uses_rc)
         && sys_clk_source == csw_pkg::SEL_PRIMARY && primary_osc_config != csw_pkg::CFG_INT_RC
         && !watchdog_uses_rc && !fail_safe_uses_rc |-> !rc_osc_pwr) else $error("internal RC left on");
   hold_cpu_a:
      assert property (first_phase_hold && watchdog_pause && !cpu_startup_done |=> first_phase_hold)
         else $error("released before CPU start-up done");
   // Main scenarios reached
   cover property ($changed(sys_clk_source) && sys_clk_source == csw_pkg::SEL_LP_OSC);
   cover property ($changed(sys_clk_source) && sys_clk_source == csw_pkg::SEL_INT_RC);
   cover property ($fell(first_phase_hold) && hold_cnt_reg > 8'h7D);
endmodule : csw_switcher_monitor
bind csw_switcher csw_switcher_monitor #(.FAST_STABLE_CYC(FAST_STABLE_CYC)) u_csw_switcher_monitor (
   .mclk(mclk), .rst(rst), .primary_osc_config(primary_osc_config), .two_speed_en(two_speed_en),
   .watchdog_uses_rc(watchdog_uses_rc), .fail_safe_uses_rc(fail_safe_uses_rc), .cpu_startup_done(cpu_startup_done),
   .sys_clk_source(sys_clk_source), .first_phase_hold(first_phase_hold), .watchdog_pause(watchdog_pause),
   .primary_osc_pwr(primary_osc_pwr), .lp_osc_pwr(lp_osc_pwr), .rc_osc_pwr(rc_osc_pwr));
`default_nettype wire

// >>> csw_switcher_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module csw_switcher_tb_top;
   localparam logic [3:0] osc_a = csw_pkg::OSC_CTRL_OFS;
   localparam logic [3:0] t1_a = csw_pkg::T1_CTRL_OFS;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [2:0] cfg = csw_pkg::CFG_STD_XTAL;
   logic two_speed = 1'b0;
   logic wdt_rc = 1'b0;
   logic fs_rc = 1'b0;
   logic cpu_done = 1'b1;
   logic [2:0] osc = 3'h0;
   logic [3:0] div = 4'h0;
   logic [1:0] src;
   logic [2:0] ifs;
   logic hold, pause, p_pwr, l_pwr, r_pwr;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   // Byte lane 0 always enabled; it is the only lane that carries register bits
   csw_switcher #(.FAST_STABLE_CYC(50)) u_csw_switcher (
      .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .primary_osc_config(cfg), .two_speed_en(two_speed),
      .watchdog_uses_rc(wdt_rc), .fail_safe_uses_rc(fs_rc), .cpu_startup_done(cpu_done),
      .primary_clk_in(osc[0]), .lp_osc_clk_in(osc[1]), .rc_osc_clk_in(osc[2]), .sys_clk_source(src),
      .internal_freq_select(ifs), .first_phase_hold(hold), .watchdog_pause(pause), .primary_osc_pwr(p_pwr),
      .lp_osc_pwr(l_pwr), .rc_osc_pwr(r_pwr));
   always #20 mclk = ~mclk;
   // Oscillators: primary every cycle, low-power every 2, internal RC every 3; also the hang limit
   always @(posedge mclk)
   begin
      div <= (div == 4'h5) ? 4'h0 : div + 4'h1;
      osc[0] <= ~osc[0];
      osc[1] <= osc[1] ^ div[0];
      osc[2] <= osc[2] ^ (div == 4'h2 || div == 4'h5);
      cycles <= cycles + 1;
      if (cycles == 25000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      // No assumed wait count: a stuck slave is caught by the bench timeout
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rd
   // Give a switch time to start, then wait for the sequencer to run again; a hang hits the timeout
   task automatic settle(output int n);
      n = 0;
      repeat (4) @(posedge mclk);
      while (pause !== 1'b0)
      begin
         @(posedge mclk);
         n++;
      end
      @(negedge mclk);
   endtask : settle
   task automatic do_reset(input logic [2:0] c, input logic ts);
      @(posedge mclk);
      rst <= 1'b1;
      cfg <= c;
      two_speed <= ts;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
   endtask : do_reset
   // Main sequence
   initial
   begin
      int n;
      do_reset(csw_pkg::CFG_STD_XTAL, 1'b0);
      @(negedge mclk);
      chk({src, hold, p_pwr, l_pwr}, 5'h06);
      rd(osc_a, 32'h00);
      settle(n);
      chk(n > 2000, 1'b1);
      rd(osc_a, 32'h08);
      rd(4'h8, 32'h00);
      // Low-power crystal in and out, first with its enable kept
      wr(t1_a, 32'h08);
      wr(osc_a, 32'h01);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk({src, hold, p_pwr}, 4'h6);
      settle(n);
      chk(n > 16, 1'b1);
      rd(osc_a, 32'h01);
      rd(t1_a, 32'h48);
      wr(osc_a, 32'h00);
      settle(n);
      chk(l_pwr, 1'b1);
      rd(osc_a, 32'h08);
      // Then leaving by clearing the enable
      wr(osc_a, 32'h01);
      settle(n);
      wr(t1_a, 32'h00);
      rd(osc_a, 32'h00);
      repeat (100) @(posedge mclk);
      @(negedge mclk);
      chk({src, hold, l_pwr, p_pwr}, 5'h0B);
      settle(n);
      chk({src, l_pwr}, 3'h0);
      rd(t1_a, 32'h00);
      // Select writes with the enable off: 01, 11, 11, 01
      for (int i = 0; i < 4; i++)
      begin
         wr(osc_a, (i == 1 || i == 2) ? 32'h03 : 32'h01);
         repeat (4) @(posedge mclk);
         @(negedge mclk);
         chk(pause, i[0]);
         settle(n);
         chk(src, (i == 1 || i == 2) ? 2'h2 : 2'h0);
         rd(osc_a, (i == 1 || i == 2) ? 32'h02 : 32'h08);
      end
      // Fast internal oscillator: stable flag after the set delay
      wr(osc_a, 32'h52);
      repeat (20) @(posedge mclk);
      rd(osc_a, 32'h52);
      repeat (60) @(posedge mclk);
      rd(osc_a, 32'h56);
      chk(ifs, 3'h5);
      wr(osc_a, 32'h50);
      settle(n);
      chk(r_pwr, 1'b0);
      @(posedge mclk);
      wdt_rc <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(r_pwr, 1'b1);
      @(posedge mclk);
      wdt_rc <= 1'b0;
      fs_rc <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(r_pwr, 1'b1);
      @(posedge mclk);
      fs_rc <= 1'b0;
      // External clock primary, CPU start-up timer late
      cpu_done <= 1'b0;
      do_reset(csw_pkg::CFG_EXT_CLK, 1'b0);
      repeat (200) @(posedge mclk);
      @(negedge mclk);
      chk(hold, 1'b1);
      @(posedge mclk);
      cpu_done <= 1'b1;
      settle(n);
      chk(n < 4, 1'b1);
      wr(osc_a, 32'h02);
      settle(n);
      wr(osc_a, 32'h00);
      settle(n);
      chk(n > 120 && n < 200, 1'b1);
      // Internal RC primary: fixed delay after reset, and the RC stays powered as the primary
      do_reset(csw_pkg::CFG_INT_RC, 1'b0);
      settle(n);
      chk(n > 110 && n < 140, 1'b1);
      chk(r_pwr, 1'b1);
      // Two-speed start-up on a crystal primary
      do_reset(csw_pkg::CFG_HS_XTAL, 1'b1);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk({src, hold}, 3'h4);
      settle(n);
      chk({src, hold}, 3'h0);
      rd(osc_a, 32'h08);
      stop_test();
   end
endmodule : csw_switcher_tb_top
`default_nettype wire
